// file: burst4_sram_pkg.sv
// Shared constants for the four-word burst dual-port DDR SRAM.
package burst4_sram_pkg;
  localparam int WORD_W        = 18;
  localparam int LANE_W        = 9;
  localparam int LANES         = 2;
  localparam int BEATS         = 4;
  localparam int BLK_W         = WORD_W * BEATS;
  localparam int ADDR_W        = 18;
  localparam int DEPTH         = 262144;
  localparam int SLOTS         = 6;
  localparam int SLOT_OFS_PLL  = 1;
  localparam int SLOT_OFS_LEG  = 0;
  localparam int SYNC_DONE     = 2;
  localparam int CLK_PERIOD_NS = 10;
  localparam int PLL_LOCK_US   = 20;
  localparam int PLL_LOCK_CYC  = (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CLK_STOP_NS   = 30;
  localparam int CLK_STOP_CYC  = (CLK_STOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECAL_CYC     = 1024;
  localparam int CNT_W         = 12;
endpackage

// file: pll_lock_ctrl.sv
// PLL lock timing, clock-stop detection and impedance recalibration tick.
`timescale 1ns/1ps
module pll_lock_ctrl (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Strap and clock status, already synchronised
  input  wire logic pll_enable,
  input  wire logic clock_running,
  // Status
  output logic      locked,
  output logic      recal_pulse
);
  logic [burst4_sram_pkg::CNT_W-1:0] lock_cnt_r;
  logic [burst4_sram_pkg::CNT_W-1:0] lock_cnt_nxt;
  logic [burst4_sram_pkg::CNT_W-1:0] stop_cnt_r;
  logic [burst4_sram_pkg::CNT_W-1:0] stop_cnt_nxt;
  logic [burst4_sram_pkg::CNT_W-1:0] recal_cnt_r;
  logic                              stopped;
  logic                              lock_done;
  logic                              recal_wrap;

  localparam logic [burst4_sram_pkg::CNT_W-1:0] LOCK_MAX =
    burst4_sram_pkg::CNT_W'(burst4_sram_pkg::PLL_LOCK_CYC);
  localparam logic [burst4_sram_pkg::CNT_W-1:0] STOP_MAX =
    burst4_sram_pkg::CNT_W'(burst4_sram_pkg::CLK_STOP_CYC);
  localparam logic [burst4_sram_pkg::CNT_W-1:0] RECAL_MAX =
    burst4_sram_pkg::CNT_W'(burst4_sram_pkg::RECAL_CYC - 1);

  assign stopped      = (stop_cnt_r >= STOP_MAX);
  assign lock_done    = (lock_cnt_r == LOCK_MAX);
  assign stop_cnt_nxt = clock_running ? '0 : (stopped ? stop_cnt_r : stop_cnt_r + 1'b1);
  // A gap shorter than the stop time only pauses the count, because only a
  // stop of full length resets the loop; such a stop clears lock.
  assign lock_cnt_nxt = (!pll_enable || stopped) ? '0 :
                        ((lock_done || !clock_running) ? lock_cnt_r
                                                       : lock_cnt_r + 1'b1);
  assign recal_wrap   = (recal_cnt_r == RECAL_MAX);
  assign locked       = pll_enable && lock_done;
  assign recal_pulse  = recal_wrap;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lock_cnt_r  <= '0;
      stop_cnt_r  <= '0;
      recal_cnt_r <= '0;
    end
    else
    begin
      lock_cnt_r  <= lock_cnt_nxt;
      stop_cnt_r  <= stop_cnt_nxt;
      recal_cnt_r <= recal_wrap ? '0 : recal_cnt_r + 1'b1;
    end
  end
endmodule

// file: burst4_dual_port_ddr_sram.sv
// Burst-of-four dual-port SRAM core with shared address, arbitration and read slots.
`timescale 1ns/1ps
module burst4_dual_port_ddr_sram (
  // Clock (the K rise) and reset
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  // Address and port selects
  input  wire logic [burst4_sram_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic                                 read_port_sel_n,
  input  wire logic                                 write_port_sel_n,
  // Write data, one word per K rise and one per K-bar rise
  input  wire logic [burst4_sram_pkg::WORD_W-1:0]   write_word_in_k,
  input  wire logic [burst4_sram_pkg::WORD_W-1:0]   write_word_in_kn,
  input  wire logic [burst4_sram_pkg::LANES-1:0]    byte_lane_sel_n_k,
  input  wire logic [burst4_sram_pkg::LANES-1:0]    byte_lane_sel_n_kn,
  // Output clock levels, straps and clock status
  input  wire logic                                 output_timing_pos,
  input  wire logic                                 output_timing_neg,
  input  wire logic                                 input_clock_running,
  input  wire logic                                 pll_on_strap,
  // Read data, one word per C rise and one per C-bar rise
  output logic      [burst4_sram_pkg::WORD_W-1:0]   read_word_out_c,
  output logic      [burst4_sram_pkg::WORD_W-1:0]   read_word_out_cn,
  output logic                                      read_word_oe,
  // Echo strobes and status
  output logic                                      echo_strobe_pos,
  output logic                                      echo_strobe_neg,
  output logic                                      pll_locked,
  output logic                                      impedance_update
);
  localparam int PIN_W = burst4_sram_pkg::ADDR_W + 2 + 2 * burst4_sram_pkg::WORD_W
                       + 2 * burst4_sram_pkg::LANES + 4;
  localparam int WW = burst4_sram_pkg::WORD_W;
  localparam int LN = burst4_sram_pkg::LANES;

  // Pin synchroniser; the first stage is read only by the second.
  logic [PIN_W-1:0] pin_s1_r;
  logic [PIN_W-1:0] pin_s2_r;

  logic [burst4_sram_pkg::ADDR_W-1:0] s_addr;
  logic                               s_rd_n;
  logic                               s_wr_n;
  logic [WW-1:0]                      s_word_k;
  logic [WW-1:0]                      s_word_kn;
  logic [LN-1:0]                      s_lane_k;
  logic [LN-1:0]                      s_lane_kn;
  logic                               s_ot_pos;
  logic                               s_ot_neg;
  logic                               s_clk_run;
  logic                               s_pll;

  assign {s_addr, s_rd_n, s_wr_n, s_word_k, s_word_kn, s_lane_k, s_lane_kn,
          s_ot_pos, s_ot_neg, s_clk_run, s_pll} = pin_s2_r;

  always_ff @(posedge clk)
  begin
    pin_s1_r <= {addr_in, read_port_sel_n, write_port_sel_n, write_word_in_k,
                 write_word_in_kn, byte_lane_sel_n_k, byte_lane_sel_n_kn,
                 output_timing_pos, output_timing_neg, input_clock_running, pll_on_strap};
    pin_s2_r <= pin_s1_r;
  end

  // Straps are caught once the synchroniser holds real pin levels.
  logic [1:0] strap_cnt_r;
  logic       strap_done_r;
  logic       pll_mode_r;
  logic       single_clk_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      strap_cnt_r  <= '0;
      strap_done_r <= 1'b0;
      pll_mode_r   <= 1'b0;
      single_clk_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_cnt_r <= strap_cnt_r + 1'b1;
      if (strap_cnt_r == 2'(burst4_sram_pkg::SYNC_DONE))
      begin
        strap_done_r <= 1'b1;
        pll_mode_r   <= s_pll;
        single_clk_r <= s_ot_pos && s_ot_neg;
      end
    end
  end

  // Arbitration between the two ports.
  logic last_rd_r;
  logic last_wr_r;
  logic rd_ok;
  logic wr_ok;
  logic start_rd;
  logic start_wr;

  // A select that started the previous cycle is ignored this cycle.
  assign rd_ok    = strap_done_r && !s_rd_n && !last_rd_r;
  assign wr_ok    = strap_done_r && !s_wr_n && !last_wr_r;
  // Read wins unless the previous cycle started a read, so both-low alternates.
  assign start_rd = rd_ok;
  assign start_wr = wr_ok && !rd_ok;

  // Write pipeline: stage 1 holds the first word pair, stage 2 commits.
  logic                               wr_v1_r;
  logic                               wr_v2_r;
  logic [burst4_sram_pkg::ADDR_W-1:0] wr_addr1_r;
  logic [burst4_sram_pkg::ADDR_W-1:0] wr_addr2_r;
  logic [WW-1:0]                      wr_w0_r;
  logic [WW-1:0]                      wr_w1_r;
  logic [LN-1:0]                      wr_l0_r;
  logic [LN-1:0]                      wr_l1_r;

  // Read pipeline: delayed two cycles so that a write begun one cycle
  // earlier has already reached the array when the read looks it up.
  logic                               rd_v1_r;
  logic                               rd_v2_r;
  logic [burst4_sram_pkg::ADDR_W-1:0] rd_addr1_r;
  logic [burst4_sram_pkg::ADDR_W-1:0] rd_addr2_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      last_rd_r  <= 1'b0;
      last_wr_r  <= 1'b0;
      wr_v1_r    <= 1'b0;
      wr_v2_r    <= 1'b0;
      rd_v1_r    <= 1'b0;
      rd_v2_r    <= 1'b0;
      wr_addr1_r <= '0;
      wr_addr2_r <= '0;
      rd_addr1_r <= '0;
      rd_addr2_r <= '0;
      wr_w0_r    <= '0;
      wr_w1_r    <= '0;
      wr_l0_r    <= '1;
      wr_l1_r    <= '1;
    end
    else
    begin
      last_rd_r  <= start_rd;
      last_wr_r  <= start_wr;
      wr_v1_r    <= start_wr;
      wr_v2_r    <= wr_v1_r;
      rd_v1_r    <= start_rd;
      rd_v2_r    <= rd_v1_r;
      if (start_wr)
        wr_addr1_r <= s_addr;
      wr_addr2_r <= wr_addr1_r;
      if (start_rd)
        rd_addr1_r <= s_addr;
      rd_addr2_r <= rd_addr1_r;
      if (wr_v1_r)
      begin
        wr_w0_r <= s_word_k;
        wr_w1_r <= s_word_kn;
        wr_l0_r <= s_lane_k;
        wr_l1_r <= s_lane_kn;
      end
    end
  end

  // Byte lane merge of one word into what the array already holds.
  function automatic logic [WW-1:0] merge_word(input logic [WW-1:0] old_w,
                                               input logic [WW-1:0] new_w,
                                               input logic [LN-1:0] lane_n);
    logic [WW-1:0] res;
    res = old_w;
    for (int l = 0; l < LN; l++)
      if (!lane_n[l])
        res[l*burst4_sram_pkg::LANE_W +: burst4_sram_pkg::LANE_W] =
          new_w[l*burst4_sram_pkg::LANE_W +: burst4_sram_pkg::LANE_W];
    return res;
  endfunction

  // One array row holds the four words of a burst, word A in the low bits.
  logic [burst4_sram_pkg::BLK_W-1:0] mem [0:burst4_sram_pkg::DEPTH-1];
  logic [burst4_sram_pkg::BLK_W-1:0] wr_old;
  logic [burst4_sram_pkg::BLK_W-1:0] wr_blk;
  logic [burst4_sram_pkg::BLK_W-1:0] rd_blk;

  assign wr_old = mem[wr_addr2_r];
  assign rd_blk = mem[rd_addr2_r];
  assign wr_blk = {merge_word(wr_old[3*WW +: WW], s_word_kn, s_lane_kn),
                   merge_word(wr_old[2*WW +: WW], s_word_k,  s_lane_k),
                   merge_word(wr_old[1*WW +: WW], wr_w1_r,   wr_l1_r),
                   merge_word(wr_old[0*WW +: WW], wr_w0_r,   wr_l0_r)};

  always_ff @(posedge clk)
  begin
    if (wr_v2_r)
      mem[wr_addr2_r] <= wr_blk;
  end

  // Read slots: pairs of half-cycle words, shifted one pair per cycle.
  logic [WW-1:0]                     slot_r   [0:burst4_sram_pkg::SLOTS-1];
  logic [WW-1:0]                     slot_nxt [0:burst4_sram_pkg::SLOTS-1];
  logic [burst4_sram_pkg::SLOTS-1:0] vld_r;
  logic [burst4_sram_pkg::SLOTS-1:0] vld_nxt;
  logic                              oe_r;
  int                                ofs;

  // PLL mode starts one half cycle later, giving 1.5 cycles instead of 1.
  assign ofs = pll_mode_r ? burst4_sram_pkg::SLOT_OFS_PLL
                          : burst4_sram_pkg::SLOT_OFS_LEG;

  always_comb
  begin
    for (int i = 0; i < burst4_sram_pkg::SLOTS; i++)
    begin
      if (i + 2 < burst4_sram_pkg::SLOTS)
      begin
        slot_nxt[i] = slot_r[i+2];
        vld_nxt[i]  = vld_r[i+2];
      end
      else
      begin
        slot_nxt[i] = '0;
        vld_nxt[i]  = 1'b0;
      end
    end
    if (rd_v2_r)
    begin
      for (int k = 0; k < burst4_sram_pkg::BEATS; k++)
      begin
        slot_nxt[k+ofs] = rd_blk[k*WW +: WW];
        vld_nxt[k+ofs]  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < burst4_sram_pkg::SLOTS; i++)
        slot_r[i] <= '0;
      vld_r <= '0;
      oe_r  <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < burst4_sram_pkg::SLOTS; i++)
        slot_r[i] <= slot_nxt[i];
      vld_r <= vld_nxt;
      // Drive stays on through the last word, then floats on the next C rise.
      oe_r  <= vld_nxt[0] || vld_nxt[1];
    end
  end

  assign read_word_out_c  = slot_r[0];
  assign read_word_out_cn = slot_r[1];
  assign read_word_oe     = oe_r;

  // Echo strobes: with one clock the K pair cannot be reproduced at full
  // rate by flops on K, so a toggle at half rate stands in for it.
  logic echo_pos_r;
  logic echo_neg_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      echo_pos_r <= 1'b0;
      echo_neg_r <= 1'b1;
    end
    else if (single_clk_r)
    begin
      echo_pos_r <= !echo_pos_r;
      echo_neg_r <= echo_pos_r;
    end
    else
    begin
      echo_pos_r <= s_ot_pos;
      echo_neg_r <= s_ot_neg;
    end
  end

  assign echo_strobe_pos = echo_pos_r;
  assign echo_strobe_neg = echo_neg_r;

  pll_lock_ctrl u_pll (
    .clk           (clk),
    .rst_n         (rst_n),
    .pll_enable    (pll_mode_r),
    .clock_running (s_clk_run),
    .locked        (pll_locked),
    .recal_pulse   (impedance_update)
  );
endmodule

// file: burst4_sram_monitor.sv
// Port-level checker for the burst SRAM core, bound to its top module.
`timescale 1ns/1ps
module burst4_sram_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Selects, straps and clock status
  input wire logic        read_port_sel_n,
  input wire logic        write_port_sel_n,
  input wire logic        output_timing_pos,
  input wire logic        output_timing_neg,
  input wire logic        input_clock_running,
  input wire logic        pll_on_strap,
  // Outputs under watch
  input wire logic [17:0] read_word_out_c,
  input wire logic [17:0] read_word_out_cn,
  input wire logic        read_word_oe,
  input wire logic        echo_strobe_pos,
  input wire logic        echo_strobe_neg,
  input wire logic        pll_locked,
  input wire logic        impedance_update
);
  logic [10:0] gap_r;
  logic        seen_r;
  logic [11:0] run_r;
  logic [3:0]  idle_r;
  logic        run_ok;
  assign run_ok = input_clock_running && pll_on_strap;
  // Counters keep long spacings checkable without long repetitions.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      gap_r  <= 11'h000;
      seen_r <= 1'b0;
      run_r  <= 12'h000;
      idle_r <= 4'h0;
    end
    else
    begin
      gap_r  <= impedance_update ? 11'h000 : gap_r + 11'h001;
      seen_r <= seen_r | impedance_update;
      run_r  <= !run_ok ? 12'h000 : run_r + {11'h000, run_r != 12'hFFF};
      idle_r <= !read_port_sel_n ? 4'h0 : idle_r + {3'h0, idle_r != 4'hF};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_recal;
    impedance_update && seen_r |-> gap_r == 11'h3FF;
  endproperty
  a_recal: assert property (p_recal) else $error("recalibration spacing wrong");
  property p_lock_time;
    $rose(pll_locked) |-> run_r >= 12'd1985 && run_r <= 12'd2015;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock came early or late");
  property p_stop;
    !input_clock_running [*3] |-> ##[0:6] !pll_locked;
  endproperty
  a_stop: assert property (p_stop) else $error("lock kept after clock stop");
  property p_float;
    idle_r == 4'hF |-> !read_word_oe;
  endproperty
  a_float: assert property (p_float) else $error("read pins still driven");
  property p_quiet;
    !read_word_oe |-> read_word_out_c == 18'h00000 && read_word_out_cn == 18'h00000;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data while not driven");
  property p_len_pll;
    $rose(read_word_oe) && pll_on_strap |-> read_word_oe [*3];
  endproperty
  a_len_pll: assert property (p_len_pll) else $error("burst span wrong");
  property p_len_leg;
    $rose(read_word_oe) && !pll_on_strap |-> read_word_oe [*2];
  endproperty
  a_len_leg: assert property (p_len_leg) else $error("legacy span wrong");
  property p_answer;
    $fell(read_port_sel_n) && write_port_sel_n |-> ##[3:7] read_word_oe;
  endproperty
  a_answer: assert property (p_answer) else $error("read not answered");
  property p_echo;
    output_timing_pos != output_timing_neg |-> ##3 echo_strobe_pos != echo_strobe_neg;
  endproperty
  a_echo: assert property (p_echo) else $error("echo strobes not paired");
endmodule

bind burst4_dual_port_ddr_sram burst4_sram_monitor mon (.clk(clk), .rst_n(rst_n),
  .read_port_sel_n(read_port_sel_n), .write_port_sel_n(write_port_sel_n),
  .output_timing_pos(output_timing_pos), .output_timing_neg(output_timing_neg),
  .input_clock_running(input_clock_running), .pll_on_strap(pll_on_strap),
  .read_word_out_c(read_word_out_c), .read_word_out_cn(read_word_out_cn),
  .read_word_oe(read_word_oe), .echo_strobe_pos(echo_strobe_pos),
  .echo_strobe_neg(echo_strobe_neg), .pll_locked(pll_locked),
  .impedance_update(impedance_update));

// file: mem_ctrl_model.sv
// Memory controller model driving the SRAM command, address and write pins.
`timescale 1ns/1ps
module mem_ctrl_model (
  // Clock, mode strap and clock status
  input  wire logic        clk,
  input  wire logic        single,
  input  wire logic        run,
  // Command and address
  output logic      [17:0] addr,
  output logic             rs,
  output logic             ws,
  // Write words and lane selects
  output logic      [17:0] wk,
  output logic      [17:0] wkn,
  output logic      [1:0]  lk,
  output logic      [1:0]  lkn,
  // Output clocks
  output logic             otp,
  output logic             otn
);
  logic tog = 1'b0;
  always @(posedge clk) tog <= ~tog;
  // Both held high from power-on selects single-clock use; both park high while stopped.
  assign otp = single | ~run | tog;
  assign otn = single | ~run | ~tog;
  initial
  begin
    addr = 18'h00000;
    rs = 1'b1;
    ws = 1'b1;
    {wk, wkn, lk, lkn} = 40'h0;
  end
  task automatic cmd(input logic r, input logic w, input logic [17:0] a);
    @(posedge clk);
    #1;
    rs = r;
    ws = w;
    addr = a;
  endtask
  // Words follow a start by one and two cycles; afterwards the lines show the inverse.
  task automatic dat(input logic [71:0] d, input logic [7:0] ln, input logic r,
                     input logic w, input logic [17:0] a);
    cmd(r, w, a);
    {wkn, wk} = d[35:0];
    {lkn, lk} = ln[3:0];
    cmd(1'b1, 1'b1, ~a);
    {wkn, wk} = d[71:36];
    {lkn, lk} = ln[7:4];
    cmd(1'b1, 1'b1, a);
    {wkn, wk, lkn, lk} = ~{wkn, wk, lkn, lk};
  endtask
endmodule

// file: burst4_dual_port_ddr_sram_test.sv
// Self-checking testbench for the burst SRAM core.
`timescale 1ns/1ps
module burst4_dual_port_ddr_sram_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        pll = 1'b1;
  logic        single = 1'b0;
  logic        run = 1'b1;
  logic [17:0] addr, wk, wkn, qc, qcn;
  logic [1:0]  lk, lkn;
  logic        rs, ws, otp, otn, oe, ep, en, lock, imp, e0;
  logic [71:0] m5;
  int          err_total = 0;
  int          tests_run = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  mem_ctrl_model ctrl (.clk(clk), .single(single), .run(run), .addr(addr), .rs(rs), .ws(ws),
    .wk(wk),
    .wkn(wkn), .lk(lk), .lkn(lkn), .otp(otp), .otn(otn));
  burst4_dual_port_ddr_sram dut (.clk(clk), .rst_n(rst_n), .addr_in(addr),
    .read_port_sel_n(rs), .write_port_sel_n(ws), .write_word_in_k(wk),
    .write_word_in_kn(wkn), .byte_lane_sel_n_k(lk), .byte_lane_sel_n_kn(lkn),
    .output_timing_pos(otp), .output_timing_neg(otn), .input_clock_running(run),
    .pll_on_strap(pll), .read_word_out_c(qc), .read_word_out_cn(qcn), .read_word_oe(oe),
    .echo_strobe_pos(ep), .echo_strobe_neg(en), .pll_locked(lock), .impedance_update(imp));
  task automatic check(input string nm, input logic [71:0] got, input logic [71:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // The ceiling leaves ample room above three lock waits of about two thousand cycles.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic do_reset(input logic p, input logic s);
    step();
    {rst_n, pll, single} = {1'b0, p, s};
    repeat (3) step();
    rst_n = 1'b1;
    repeat (4) step();
  endtask
  function automatic logic [71:0] merge(input logic [71:0] o, n, input logic [7:0] ln);
    merge = o;
    for (int i = 0; i < 8; i++)
      if (!ln[i]) merge[9*i +: 9] = n[9*i +: 9];
  endfunction
  task automatic get(input logic [71:0] e);
    for (int i = 0; i < 12 && oe !== 1'b1; i++) step();
    check("read enable", oe, 72'h1);
    if (pll)
    begin
      check("word a", qcn, e[17:0]);
      step();
      check("word a1", {qcn, qc}, e[53:18]);
      step();
      check("word a3", qc, e[71:54]);
    end
    else
    begin
      check("legacy a", {qcn, qc}, e[35:0]);
      step();
      check("legacy a2", {qcn, qc}, e[71:36]);
    end
  endtask
  task automatic wr(input logic [17:0] a, input logic [71:0] d, input logic [7:0] ln);
    ctrl.cmd(1'b1, 1'b0, a);
    ctrl.dat(d, ln, 1'b1, 1'b1, a);
  endtask
  task automatic rd(input logic [17:0] a, input logic [71:0] e);
    ctrl.cmd(1'b0, 1'b1, a);
    ctrl.cmd(1'b1, 1'b1, ~a);
    get(e);
  endtask
  task automatic t_idle;
    check("idle outputs", {oe, qc, qcn, lock, imp}, 72'h0);
    $display("idle done");
  endtask
  task automatic t_mask;
    wr(18'h00005, 72'h123456789ABCDEF012, 8'h00);
    rd(18'h00005, 72'h123456789ABCDEF012);
    m5 = merge(72'h123456789ABCDEF012, 72'hFEDCBA9876543210AB, 8'h36);
    wr(18'h00005, 72'hFEDCBA9876543210AB, 8'h36);
    rd(18'h00005, m5);
    $display("write and mask done");
  endtask
  task automatic t_ignore;
    wr(18'h00009, 72'h0F0F0F0F0F0F0F0F0F, 8'h00);
    ctrl.cmd(1'b1, 1'b0, 18'h00007);
    ctrl.dat(72'hA5A5A5A5A5A5A5A5A5, 8'h00, 1'b1, 1'b0, 18'h00009);
    rd(18'h00009, 72'h0F0F0F0F0F0F0F0F0F);
    rd(18'h00007, 72'hA5A5A5A5A5A5A5A5A5);
    $display("ignored write done");
  endtask
  task automatic t_fwd;
    ctrl.cmd(1'b1, 1'b0, 18'h00003);
    ctrl.dat(72'h3C3C3C3C3C3C3C3C3C, 8'h00, 1'b0, 1'b1, 18'h00003);
    get(72'h3C3C3C3C3C3C3C3C3C);
    $display("forwarding done");
  endtask
  task automatic t_both;
    ctrl.cmd(1'b0, 1'b0, 18'h00005);
    ctrl.cmd(1'b0, 1'b0, 18'h0000B);
    ctrl.dat(72'h77665544332211000F, 8'h00, 1'b1, 1'b1, 18'h0000B);
    get(m5);
    rd(18'h0000B, 72'h77665544332211000F);
    $display("arbitration done");
  endtask
  task automatic t_twice;
    ctrl.cmd(1'b0, 1'b1, 18'h00009);
    ctrl.cmd(1'b0, 1'b1, 18'h00005);
    ctrl.cmd(1'b1, 1'b1, 18'h00000);
    get(72'h0F0F0F0F0F0F0F0F0F);
    step();
    check("second read refused", oe, 72'h0);
    $display("double read done");
  endtask
  task automatic t_lock;
    int gap;
    for (int i = 0; i < 3000 && lock !== 1'b1; i++) step();
    check("locked", lock, 72'h1);
    check("lock delay", cyc >= 2000, 72'h1);
    run = 1'b0;
    repeat (2) step();
    run = 1'b1;
    repeat (4) step();
    check("lock kept", lock, 72'h1);
    run = 1'b0;
    repeat (8) step();
    check("lock lost", lock, 72'h0);
    run = 1'b1;
    for (int i = 0; i < 1100 && imp !== 1'b1; i++) step();
    step();
    gap = 1;
    for (int i = 0; i < 1100 && imp !== 1'b1; i++)
    begin
      step();
      gap++;
    end
    check("recal spacing", 72'(gap), 72'(burst4_sram_pkg::RECAL_CYC));
    for (int i = 0; i < 3000 && lock !== 1'b1; i++) step();
    check("relocked", lock, 72'h1);
    $display("lock done");
  endtask
  task automatic t_legacy;
    do_reset(1'b0, 1'b0);
    wr(18'h00005, 72'h13579BDF02468ACE11, 8'h00);
    rd(18'h00005, 72'h13579BDF02468ACE11);
    check("no lock", lock, 72'h0);
    $display("legacy done");
  endtask
  task automatic t_single;
    do_reset(1'b1, 1'b1);
    e0 = ep;
    step();
    check("echo toggles", ep, {71'h0, ~e0});
    check("echo lags", en, {71'h0, e0});
    for (int i = 0; i < 3000 && lock !== 1'b1; i++) step();
    check("single lock", lock, 72'h1);
    wr(18'h00002, 72'h2468ACE013579BDF22, 8'h00);
    rd(18'h00002, 72'h2468ACE013579BDF22);
    $display("single clock done");
  endtask
  initial
  begin
    do_reset(1'b1, 1'b0);
    t_idle();
    t_lock();
    t_mask();
    t_ignore();
    t_fwd();
    t_both();
    t_twice();
    t_legacy();
    t_single();
    finish_test();
  end
endmodule
